// [core/iews_map.svh]
`ifndef IEWS_MAP_SVH
`define IEWS_MAP_SVH

// Fixed upper five bits of the memory slave address.
`define IEWS_MEM_PREFIX     5'h14
// Fixed upper five bits of the wiper slave address.
`define IEWS_WIPER_PREFIX   5'h0b

`define IEWS_MID9           9'h100
`define IEWS_MID7           7'h40
`define IEWS_WIPER_LAST     3'h4
`define IEWS_BYTE_BITS      4'h8
`define IEWS_TX_LAST        4'h7

`define IEWS_MCLK_MHZ       200
`define IEWS_STORE_MS       26
`define IEWS_RESTORE_US     360
`define IEWS_STORE_CYCLES   (`IEWS_STORE_MS * 1000 * `IEWS_MCLK_MHZ)
`define IEWS_RESTORE_CYCLES (`IEWS_RESTORE_US * `IEWS_MCLK_MHZ)

`endif

// [core/iews_nv_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "iews_map.svh"

module iews_nv_timer #(
    parameter int unsigned STORE_CYCLES   = `IEWS_STORE_CYCLES,
    parameter int unsigned RESTORE_CYCLES = `IEWS_RESTORE_CYCLES
) (
    input  wire logic i_mclk,
    input  wire logic i_rstn,
    input  wire logic i_store_tgl,
    output var  logic o_busy,
    output var  logic o_restore
);

    localparam logic [22:0] STORE_LAST   = 23'(STORE_CYCLES - 1);
    localparam logic [22:0] RESTORE_LAST = 23'(RESTORE_CYCLES - 1);

    iews_pkg::iews_tmr_t r;
    iews_pkg::iews_tmr_t next_r;
    logic                store_evt;

    always_comb begin
        next_r = r;
        next_r.tsync = {r.tsync[1:0], i_store_tgl};
        store_evt = r.tsync[2] ^ r.tsync[1];
        unique case (r.st)
            iews_pkg::T_RESTORE: begin
                next_r.cnt = r.cnt + 23'h00_0001;
                if (r.cnt == RESTORE_LAST) begin
                    next_r.st      = iews_pkg::T_IDLE;
                    next_r.busy    = 1'b0;
                    next_r.restore = 1'b0;
                end
            end
            iews_pkg::T_STORE: begin
                next_r.cnt = r.cnt + 23'h00_0001;
                if (r.cnt == STORE_LAST) begin
                    next_r.st   = iews_pkg::T_IDLE;
                    next_r.busy = 1'b0;
                end
            end
            iews_pkg::T_IDLE: begin
                if (store_evt) begin
                    next_r.st   = iews_pkg::T_STORE;
                    next_r.cnt  = 23'h00_0000;
                    next_r.busy = 1'b1;
                end
            end
            default: begin
                next_r.st = iews_pkg::T_IDLE;
            end
        endcase
    end

    // The power-on restore runs straight out of reset, so the interface is held off.
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            r <= '{st: iews_pkg::T_RESTORE, cnt: 23'h00_0000, tsync: 3'h0, busy: 1'b1,
                   restore: 1'b1};
        end else begin
            r <= next_r;
        end
    end

    assign o_busy    = r.busy;
    assign o_restore = r.restore;

endmodule : iews_nv_timer
`default_nettype wire

// [core/iews_pkg.sv]
package iews_pkg;

    typedef enum logic [2:0] {
        L_IDLE   = 3'h0,
        L_RX     = 3'h1,
        L_RX_ACK = 3'h2,
        L_TX     = 3'h3,
        L_TX_ACK = 3'h4
    } iews_lstate_t;

    typedef enum logic [1:0] {
        K_SLAVE = 2'h0,
        K_WADDR = 2'h1,
        K_DATA  = 2'h2
    } iews_kind_t;

    typedef enum logic [1:0] {
        T_IDLE    = 2'h0,
        T_RESTORE = 2'h1,
        T_STORE   = 2'h2
    } iews_tstate_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic wp_n;
        logic reload_n;
        logic mem_addr_sel_hi;
        logic mem_addr_sel_lo;
        logic wiper_addr_sel_hi;
        logic wiper_addr_sel_lo;
        logic busy;
        logic restore;
        logic rstn;
    } iews_pins_t;

    typedef struct packed {
        iews_lstate_t st;
        iews_kind_t   kind;
        logic [3:0]   cnt;
        logic [7:0]   shift;
        logic [7:0]   tx;
        logic         to_mem;
        logic         to_wip;
        logic         rd;
        logic         wrote;
        logic         macked;
        logic [7:0]   ctr;
        logic [2:0]   wptr;
        logic         tgl;
        logic         pending;
        logic         scl_d;
        logic         sda_d;
        logic         sda_oe;
        logic         sda_o;
        logic [8:0]   w0;
        logic [8:0]   w1;
        logic [6:0]   w2;
        logic [8:0]   nv0;
        logic [8:0]   nv1;
        logic [6:0]   nv2;
    } iews_link_t;

    typedef struct packed {
        iews_tstate_t st;
        logic [22:0]  cnt;
        logic [2:0]   tsync;
        logic         busy;
        logic         restore;
    } iews_tmr_t;

endpackage : iews_pkg

// [core/iews_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "iews_map.svh"

// What this block does
// - Reload pin low copies every stored wiper value into the wiper registers.
// - Stored wiper values start at midscale before any programming.
// - Write-protect low blocks content changes; reload still refreshes the wipers.
// - Data bits are sampled on rising clock edges, most significant bit first.
// - The memory holds 256 bytes as 16 pages of 16 bytes.
// - Memory slave address is the fixed prefix plus two strapped pins.
// - Wiper registers answer at a second address with their own pin pair.
// - An 8-bit memory address counter advances after every byte read or written.
// - Reads wrap the counter from the last location back to zero.
// - Writes wrap the counter inside the current page only.
// - More than 16 bytes in one write overwrite the same page again.
// - A completed memory write starts a store cycle; no acknowledge until it ends.
// - A polling address is acknowledged only after the store cycle ends.
// - A current read returns data from the address counter's location.
// - An address-only write loads the counter for a following read.
// - Write-protect low blocks programming; reads and wiper loading still work.
// - Each store cycle lasts about 26 ms with the interface unavailable.
// - The power-on restore of the wiper registers takes about 360 us.
module iews_top #(
    parameter int unsigned STORE_CYCLES   = `IEWS_STORE_CYCLES,
    parameter int unsigned RESTORE_CYCLES = `IEWS_RESTORE_CYCLES
) (
    input  wire logic       i_mclk,
    input  wire logic       i_rstn,
    input  wire logic       i_link_clk,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output var  logic       o_sda_o,
    output var  logic       o_sda_oe,
    input  wire logic       i_wp_n,
    input  wire logic       i_reload_n,
    input  wire logic       i_mem_addr_sel_hi,
    input  wire logic       i_mem_addr_sel_lo,
    input  wire logic       i_wiper_addr_sel_hi,
    input  wire logic       i_wiper_addr_sel_lo,
    output var  logic [8:0] o_wiper0,
    output var  logic [8:0] o_wiper1,
    output var  logic [6:0] o_wiper2
);

    iews_pkg::iews_pins_t pin_raw;
    iews_pkg::iews_pins_t pin_meta;
    iews_pkg::iews_pins_t pin_sync;
    iews_pkg::iews_link_t r;
    iews_pkg::iews_link_t next_r;

    logic [7:0] nonvolatile_store [0:255];
    logic       mem_we;
    logic [7:0] mem_wa;
    logic [7:0] mem_wd;
    logic       tmr_busy;
    logic       tmr_restore;
    logic       scl_rise;
    logic       scl_fall;
    logic       start;
    logic       stop;
    logic       busy_any;
    logic       ack;
    logic [6:0] mem_sa;
    logic [6:0] wip_sa;
    logic [7:0] rbyte;

    localparam iews_pkg::iews_link_t LINK_RST = '{
        st: iews_pkg::L_IDLE, kind: iews_pkg::K_SLAVE, cnt: 4'h0, shift: 8'h00,
        tx: 8'h00, to_mem: 1'b0, to_wip: 1'b0, rd: 1'b0, wrote: 1'b0, macked: 1'b0,
        ctr: 8'h00, wptr: 3'h0, tgl: 1'b0, pending: 1'b0, scl_d: 1'b1, sda_d: 1'b1,
        sda_oe: 1'b0, sda_o: 1'b0,
        w0: `IEWS_MID9, w1: `IEWS_MID9, w2: `IEWS_MID7,
        nv0: `IEWS_MID9, nv1: `IEWS_MID9, nv2: `IEWS_MID7
    };

    iews_nv_timer #(
        .STORE_CYCLES   (STORE_CYCLES),
        .RESTORE_CYCLES (RESTORE_CYCLES)
    ) u_timer (
        .i_mclk      (i_mclk),
        .i_rstn      (i_rstn),
        .i_store_tgl (r.tgl),
        .o_busy      (tmr_busy),
        .o_restore   (tmr_restore)
    );

    assign pin_raw.scl               = i_scl;
    assign pin_raw.sda               = i_sda;
    assign pin_raw.wp_n              = i_wp_n;
    assign pin_raw.reload_n          = i_reload_n;
    assign pin_raw.mem_addr_sel_hi   = i_mem_addr_sel_hi;
    assign pin_raw.mem_addr_sel_lo   = i_mem_addr_sel_lo;
    assign pin_raw.wiper_addr_sel_hi = i_wiper_addr_sel_hi;
    assign pin_raw.wiper_addr_sel_lo = i_wiper_addr_sel_lo;
    assign pin_raw.busy              = tmr_busy;
    assign pin_raw.restore           = tmr_restore;
    assign pin_raw.rstn              = i_rstn;

    // Every pin and every signal from the system clock crosses on two flops here.
    always_ff @(posedge i_link_clk) begin
        pin_meta <= pin_raw;
        pin_sync <= pin_meta;
    end

    always_comb begin
        next_r   = r;
        mem_we   = 1'b0;
        mem_wa   = r.ctr;
        mem_wd   = r.shift;
        ack      = 1'b0;
        next_r.scl_d = pin_sync.scl;
        next_r.sda_d = pin_sync.sda;
        scl_rise = pin_sync.scl & ~r.scl_d;
        scl_fall = ~pin_sync.scl & r.scl_d;
        start    = pin_sync.scl & r.scl_d & r.sda_d & ~pin_sync.sda;
        stop     = pin_sync.scl & r.scl_d & ~r.sda_d & pin_sync.sda;
        // The local flag covers the crossing delay before the timer reports busy.
        busy_any = r.pending | pin_sync.busy;
        mem_sa   = {`IEWS_MEM_PREFIX, pin_sync.mem_addr_sel_hi,
                    pin_sync.mem_addr_sel_lo};
        wip_sa   = {`IEWS_WIPER_PREFIX, pin_sync.wiper_addr_sel_hi,
                    pin_sync.wiper_addr_sel_lo};
        if (r.to_mem) begin
            rbyte = nonvolatile_store[r.ctr];
        end else begin
            unique case (r.wptr)
                3'h0:    rbyte = r.w0[7:0];
                3'h1:    rbyte = {7'h00, r.w0[8]};
                3'h2:    rbyte = r.w1[7:0];
                3'h3:    rbyte = {7'h00, r.w1[8]};
                3'h4:    rbyte = {1'b0, r.w2};
                default: rbyte = 8'h00;
            endcase
        end
        if (r.pending && pin_sync.busy) begin
            next_r.pending = 1'b0;
        end

        if (start) begin
            next_r.st     = iews_pkg::L_RX;
            next_r.kind   = iews_pkg::K_SLAVE;
            next_r.cnt    = 4'h0;
            next_r.sda_oe = 1'b0;
            next_r.to_mem = 1'b0;
            next_r.to_wip = 1'b0;
        end else if (stop) begin
            next_r.st     = iews_pkg::L_IDLE;
            next_r.sda_oe = 1'b0;
        end else begin
            unique case (r.st)
                iews_pkg::L_IDLE: begin
                end
                iews_pkg::L_RX: begin
                    if (scl_rise) begin
                        next_r.shift = {r.shift[6:0], pin_sync.sda};
                        next_r.cnt   = r.cnt + 4'h1;
                    end else if (scl_fall && r.cnt == `IEWS_BYTE_BITS) begin
                        next_r.cnt = 4'h0;
                        unique case (r.kind)
                            iews_pkg::K_SLAVE: begin
                                // While storing, polling addresses get no acknowledge.
                                if (!busy_any && r.shift[7:1] == mem_sa) begin
                                    next_r.to_mem = 1'b1;
                                    ack           = 1'b1;
                                end else if (!busy_any && r.shift[7:1] == wip_sa) begin
                                    next_r.to_wip = 1'b1;
                                    ack           = 1'b1;
                                end
                                next_r.rd = r.shift[0];
                            end
                            iews_pkg::K_WADDR: begin
                                ack = 1'b1;
                                if (r.to_mem) begin
                                    next_r.ctr = r.shift;
                                end else begin
                                    next_r.wptr = r.shift[2:0];
                                end
                            end
                            iews_pkg::K_DATA: begin
                                ack = 1'b1;
                                if (r.to_mem) begin
                                    if (pin_sync.wp_n) begin
                                        mem_we       = 1'b1;
                                        next_r.wrote = 1'b1;
                                    end
                                    next_r.ctr = {r.ctr[7:4], r.ctr[3:0] + 4'h1};
                                end else begin
                                    if (pin_sync.wp_n) begin
                                        unique case (r.wptr)
                                            3'h0:    next_r.w0[7:0] = r.shift;
                                            3'h1:    next_r.w0[8]   = r.shift[0];
                                            3'h2:    next_r.w1[7:0] = r.shift;
                                            3'h3:    next_r.w1[8]   = r.shift[0];
                                            3'h4:    next_r.w2      = r.shift[6:0];
                                            default: begin
                                            end
                                        endcase
                                    end
                                    next_r.wptr = (r.wptr == `IEWS_WIPER_LAST) ? 3'h0
                                                : r.wptr + 3'h1;
                                end
                            end
                            default: begin
                            end
                        endcase
                        if (ack) begin
                            next_r.st     = iews_pkg::L_RX_ACK;
                            next_r.sda_oe = 1'b1;
                        end else begin
                            next_r.st = iews_pkg::L_IDLE;
                        end
                    end
                end
                iews_pkg::L_RX_ACK: begin
                    if (scl_fall) begin
                        next_r.sda_oe = 1'b0;
                        if (r.kind == iews_pkg::K_SLAVE && r.rd) begin
                            next_r.st     = iews_pkg::L_TX;
                            next_r.tx     = rbyte;
                            next_r.sda_oe = ~rbyte[7];
                            if (r.to_mem) begin
                                next_r.ctr = r.ctr + 8'h01;
                            end else begin
                                next_r.wptr = (r.wptr == `IEWS_WIPER_LAST) ? 3'h0
                                            : r.wptr + 3'h1;
                            end
                        end else begin
                            next_r.st   = iews_pkg::L_RX;
                            next_r.kind = (r.kind == iews_pkg::K_SLAVE) ? iews_pkg::K_WADDR
                                        : iews_pkg::K_DATA;
                        end
                    end
                end
                iews_pkg::L_TX: begin
                    if (scl_fall) begin
                        if (r.cnt == `IEWS_TX_LAST) begin
                            next_r.cnt    = 4'h0;
                            next_r.sda_oe = 1'b0;
                            next_r.st     = iews_pkg::L_TX_ACK;
                        end else begin
                            next_r.tx     = {r.tx[6:0], 1'b0};
                            next_r.sda_oe = ~r.tx[6];
                            next_r.cnt    = r.cnt + 4'h1;
                        end
                    end
                end
                iews_pkg::L_TX_ACK: begin
                    if (scl_rise) begin
                        next_r.macked = ~pin_sync.sda;
                    end else if (scl_fall) begin
                        if (r.macked) begin
                            next_r.st     = iews_pkg::L_TX;
                            next_r.tx     = rbyte;
                            next_r.sda_oe = ~rbyte[7];
                            if (r.to_mem) begin
                                next_r.ctr = r.ctr + 8'h01;
                            end else begin
                                next_r.wptr = (r.wptr == `IEWS_WIPER_LAST) ? 3'h0
                                            : r.wptr + 3'h1;
                            end
                        end else begin
                            next_r.st = iews_pkg::L_IDLE;
                        end
                    end
                end
                default: begin
                    next_r.st     = iews_pkg::L_IDLE;
                    next_r.sda_oe = 1'b0;
                end
            endcase
        end

        // A repeated start also closes a write, so the store cycle is never skipped.
        if ((start || stop) && r.wrote) begin
            next_r.tgl     = ~r.tgl;
            next_r.pending = 1'b1;
            next_r.wrote   = 1'b0;
        end

        // Reload wins over a serial write in the same cycle; protection never blocks it.
        if (pin_sync.restore || !pin_sync.reload_n) begin
            next_r.w0 = r.nv0;
            next_r.w1 = r.nv1;
            next_r.w2 = r.nv2;
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (!pin_sync.rstn) begin
            r <= LINK_RST;
        end else begin
            r <= next_r;
        end
    end

    // Contents are not reset; a read of an unwritten byte returns whatever the array holds.
    always_ff @(posedge i_link_clk) begin
        if (mem_we) begin
            nonvolatile_store[mem_wa] <= mem_wd;
        end
    end

    assign o_sda_o  = r.sda_o;
    assign o_sda_oe = r.sda_oe;
    assign o_wiper0 = r.w0;
    assign o_wiper1 = r.w1;
    assign o_wiper2 = r.w2;

endmodule : iews_top
`default_nettype wire

// [test/iews_master.sv]
`timescale 1ns/1ps
`default_nettype none

module iews_master (
    input  wire logic i_mclk,
    input  wire logic i_sda,
    output var  logic o_scl,
    output var  logic o_pull
);
    // A quarter bit of 32 clocks keeps every level well above four link cycles.
    localparam int Q = 32;
    initial begin
        o_scl = 1'b1;
        o_pull = 1'b0;
    end
    task automatic step(input logic c, input logic p);
        repeat (Q) @(negedge i_mclk);
        o_scl = c;
        o_pull = p;
    endtask : step
    task automatic bit_io(input logic b, output logic r);
        step(1'b0, ~b);
        step(1'b1, ~b);
        repeat (2 * Q) @(negedge i_mclk);
        r = i_sda;
        o_scl = 1'b0;
    endtask : bit_io
    task automatic start();
        step(o_scl, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask : start
    task automatic stop();
        step(o_scl, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask : stop
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = r === 1'b0;
    endtask : wr_byte
    task automatic rd_byte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(~mack, r);
    endtask : rd_byte
endmodule : iews_master
`default_nettype wire

// [test/iews_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "iews_map.svh"

module iews_monitor (
    input wire logic       i_rstn,
    input wire logic       i_link_clk,
    input wire logic       i_scl,
    input wire logic       i_wp_n,
    input wire logic       i_reload_n,
    input wire logic       o_sda_o,
    input wire logic       o_sda_oe,
    input wire logic [8:0] o_wiper0,
    input wire logic [8:0] o_wiper1,
    input wire logic [6:0] o_wiper2
);
    wire mid = {o_wiper0, o_wiper1, o_wiper2} == {`IEWS_MID9, `IEWS_MID9, `IEWS_MID7};
    default clocking dc @(posedge i_link_clk);
    endclocking
    default disable iff (!i_rstn);

    // The link side sees reset through two flops, so its effect lags by two link cycles.
    a_reset_released: assert property (disable iff (1'b0) !i_rstn [*2] |-> ##2 !o_sda_oe)
        else $error("data line driven in reset");
    a_reset_midscale: assert property (disable iff (1'b0) !i_rstn [*2] |-> ##2 mid)
        else $error("wipers not midscale in reset");
    a_reload_copies: assert property (!i_reload_n [*5] |-> mid)
        else $error("reload did not restore wipers");
    a_protect_reload: assert property ((!i_reload_n && !i_wp_n) [*5] |-> mid)
        else $error("reload blocked while protected");
    a_protect_freeze: assert property ((!i_wp_n && i_reload_n) [*5] |=>
        $stable(o_wiper0) && $stable(o_wiper1) && $stable(o_wiper2))
        else $error("wipers changed while protected");
    a_open_drain: assert property (!o_sda_o)
        else $error("data line driven high");
    a_change_scl_low: assert property ($changed(o_sda_oe) |->
        !i_scl && !$past(i_scl) && !$past(i_scl, 2)) else $error("data moved near clock high");
    a_hold_scl_high: assert property (i_scl [*3] |=> $stable(o_sda_oe))
        else $error("data moved while clock high");
    c_ack: cover property ($rose(o_sda_oe));
    c_reload: cover property (!i_reload_n [*5]);
    c_protect: cover property ((!i_wp_n && i_reload_n) [*5]);
endmodule : iews_monitor

bind iews_top iews_monitor u_iews_monitor (
    .i_rstn(i_rstn), .i_link_clk(i_link_clk), .i_scl(i_scl), .i_wp_n(i_wp_n),
    .i_reload_n(i_reload_n), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
    .o_wiper0(o_wiper0), .o_wiper1(o_wiper1), .o_wiper2(o_wiper2)
);
`default_nettype wire

// [test/tb_i2c_eeprom_wiper_store.sv]
`timescale 1ns/1ps
`default_nettype none
`include "iews_map.svh"

`define CHK(n, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("CHECK FAILED %s expected %h seen %h", n, e, g); \
    end \
end

module tb_i2c_eeprom_wiper_store;
    localparam int          RESTORE = 50;
    localparam logic [24:0] MID     = {`IEWS_MID9, `IEWS_MID9, `IEWS_MID7};
    logic       mclk     = 1'b0;
    logic       link_clk = 1'b0;
    logic       rstn     = 1'b0;
    logic       wp_n     = 1'b1;
    logic       reload_n = 1'b1;
    logic [1:0] msel     = 2'h2;
    logic [1:0] wsel     = 2'h1;
    logic       scl;
    logic       pull;
    logic       sda_oe;
    logic [8:0] w0;
    logic [8:0] w1;
    logic [6:0] w2;
    int         err_total  = 0;
    int         num_checks = 0;
    // The bus is pulled up, so it reads low whenever either party pulls.
    wire        sda = ~(pull | sda_oe);

    iews_top #(.STORE_CYCLES(3000), .RESTORE_CYCLES(RESTORE)) u_iews_top (
        .i_mclk(mclk), .i_rstn(rstn), .i_link_clk(link_clk), .i_scl(scl), .i_sda(sda),
        .o_sda_o(), .o_sda_oe(sda_oe), .i_wp_n(wp_n), .i_reload_n(reload_n),
        .i_mem_addr_sel_hi(msel[1]), .i_mem_addr_sel_lo(msel[0]),
        .i_wiper_addr_sel_hi(wsel[1]), .i_wiper_addr_sel_lo(wsel[0]),
        .o_wiper0(w0), .o_wiper1(w1), .o_wiper2(w2)
    );
    iews_master u_iews_master (.i_mclk(mclk), .i_sda(sda), .o_scl(scl), .o_pull(pull));

    initial begin
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        #7.3;
        forever #15 link_clk = ~link_clk;
    end

    function automatic logic [7:0] sa(input logic wip, input logic rd);
        return {wip ? `IEWS_WIPER_PREFIX : `IEWS_MEM_PREFIX, wip ? wsel : msel, rd};
    endfunction : sa
    task automatic ab(input logic [7:0] b, input logic e, input string n);
        logic a;
        u_iews_master.wr_byte(b, a);
        `CHK(n, e, a)
    endtask : ab
    task automatic probe(input logic [7:0] b, output logic a);
        u_iews_master.start();
        u_iews_master.wr_byte(b, a);
        u_iews_master.stop();
    endtask : probe
    task automatic poll(input int exp_n);
        logic a = 1'b0;
        int   n = 0;
        while (!a && n < 20) begin
            probe(sa(1'b0, 1'b0), a);
            n++;
        end
        `CHK("polls to ack", exp_n, n)
    endtask : poll
    task automatic mem_write(input logic [7:0] a, input int n, input logic [7:0] d0);
        u_iews_master.start();
        ab(sa(1'b0, 1'b0), 1'b1, "write sel");
        ab(a, 1'b1, "write addr");
        for (int k = 0; k < n; k++) ab(8'(d0 + k), 1'b1, "write data");
        u_iews_master.stop();
    endtask : mem_write
    task automatic mem_read(input logic [7:0] a, input logic rnd, input int n,
                            input logic [23:0] e);
        logic [7:0] d;
        u_iews_master.start();
        if (rnd) begin
            ab(sa(1'b0, 1'b0), 1'b1, "dummy sel");
            ab(a, 1'b1, "dummy addr");
            u_iews_master.start();
        end
        ab(sa(1'b0, 1'b1), 1'b1, "read sel");
        for (int k = 0; k < n; k++) begin
            u_iews_master.rd_byte(k < n - 1, d);
            `CHK("read data", e[23 - 8 * k -: 8], d)
        end
        u_iews_master.stop();
    endtask : mem_read
    task automatic wip_write(input logic [39:0] b);
        u_iews_master.start();
        ab(sa(1'b1, 1'b0), 1'b1, "wiper sel");
        ab(8'h00, 1'b1, "wiper ptr");
        for (int k = 0; k < 5; k++) ab(b[39 - 8 * k -: 8], 1'b1, "wiper data");
        u_iews_master.stop();
    endtask : wip_write

    task automatic t_power_on();
        `CHK("restored wipers", MID, {w0, w1, w2})
    endtask : t_power_on
    task automatic t_page_write();
        mem_write(8'h0E, 17, 8'hA0);
        poll(3);
        mem_read(8'h00, 1'b0, 1, 24'hA1_0000);
        mem_read(8'h0C, 1'b1, 3, 24'hAE_AFB0);
    endtask : t_page_write
    task automatic t_read_wrap();
        mem_write(8'hFF, 1, 8'h5A);
        poll(3);
        mem_read(8'hFF, 1'b1, 3, 24'h5A_A2A3);
    endtask : t_read_wrap
    task automatic t_wiper();
        wip_write(40'h3C_0177_0015);
        `CHK("wipers set", {9'h13C, 9'h077, 7'h15}, {w0, w1, w2})
    endtask : t_wiper
    task automatic t_protect();
        wp_n = 1'b0;
        mem_write(8'h05, 1, 8'h33);
        poll(1);
        mem_read(8'h05, 1'b1, 1, 24'hA7_0000);
        wip_write(40'h01_0000_0000);
        `CHK("wipers kept", {9'h13C, 9'h077, 7'h15}, {w0, w1, w2})
        reload_n = 1'b0;
        repeat (60) @(negedge mclk);
        reload_n = 1'b1;
        `CHK("reloaded wipers", MID, {w0, w1, w2})
        wp_n = 1'b1;
    endtask : t_protect
    task automatic t_address();
        logic a;
        msel = 2'h1;
        probe(8'hA4, a);
        `CHK("stale mem sel", 1'b0, a)
        probe(8'hA2, a);
        `CHK("new mem sel", 1'b1, a)
        probe(8'h5C, a);
        `CHK("foreign wiper sel", 1'b0, a)
    endtask : t_address

    task automatic end_sim();
        if (err_total == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    initial begin
        repeat (12) @(negedge mclk);
        rstn = 1'b1;
        repeat (RESTORE + 20) @(negedge mclk);
        t_power_on();
        t_page_write();
        t_read_wrap();
        t_wiper();
        t_protect();
        t_address();
        end_sim();
    end
    initial begin
        // The full sequence needs roughly 82,000 system clocks at this bit rate.
        repeat (90000) @(posedge mclk);
        err_total++;
        end_sim();
    end
endmodule : tb_i2c_eeprom_wiper_store
`default_nettype wire
